// ### common/sram_port_pkg.sv
package sram_port_pkg;
    localparam int DATA_W_X36 = 36;
    localparam int DATA_W_X18 = 18;
    localparam int BURST_ADDR_W_X36 = 19;
    localparam int BURST_ADDR_W_X18 = 20;
    localparam int BYTE_W = 9;
    localparam int BURST_LEN = 4;
    localparam int BEAT_W = 2;
    // read latency counted in half cycles of the input clock
    localparam int RD_LAT_HALF = 5;
    localparam int RD_LAT_BYP_HALF = 2;
    localparam int BYPASS_MAX_MHZ = 167;
    localparam int MCLK_MHZ = 100;
    localparam int WBUF_DEPTH = 2;
endpackage : sram_port_pkg

// ### sim/mem_ctrl_model.sv
`timescale 1ns/1ns
module mem_ctrl_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    output logic k_o,
    output logic kn_o,
    output logic rsel_n_o,
    output logic wsel_n_o,
    output logic [3:0] addr_o,
    output logic [35:0] wdata_o,
    output logic [3:0] bw_n_o
);
    // start stopped so the clock pins never float unknown before reset ends
    logic [3:0] cnt = 4'h8;
    logic run = 1'b0;
    int nrise;
    int ncyc;
    // input clock pair, 16 mclk per period, k# is the inverse of k while running
    assign k_o = run & ~cnt[3];
    assign kn_o = run & cnt[3];
    initial begin
        rsel_n_o = 1'b1;
        wsel_n_o = 1'b1;
        addr_o = 4'h0;
        wdata_o = 36'h0_0000_0000;
        bw_n_o = 4'hf;
    end
    // held low until the device has left reset and its sync pipe is clear
    always @(negedge mclk_i) begin
        ncyc <= rst_n_i ? ncyc + 1 : 0;
        run <= rst_n_i && ncyc >= 4;
        if (!run) cnt <= 4'h8;
        else cnt <= cnt + 4'h1;
        if (!run) nrise <= 0;
        else if (cnt == 4'hf) nrise <= nrise + 1;
    end
    // wait for a slot; par picks the parity of the next k rise
    task automatic slot(input int v, input int par);
        do @(negedge mclk_i); while (cnt != v || (par >= 0 && nrise[0] != par));
    endtask : slot
    // select held from the k fall before the rise to mid-high after it
    task automatic rd(input logic [3:0] a, input int par, output int t);
        slot(7, par);
        rsel_n_o <= 1'b0;
        addr_o <= a;
        slot(15, -1);
        t = ncyc;
        slot(3, -1);
        rsel_n_o <= 1'b1;
        addr_o <= ~a; // released lines show the inverse
    endtask : rd
    task automatic wr(input logic [3:0] a, input int par, input logic [143:0] d,
                      input logic [15:0] bw);
        slot(7, par);
        wsel_n_o <= 1'b0;
        addr_o <= a;
        slot(3, -1);
        wsel_n_o <= 1'b1;
        addr_o <= ~a;
        // beats change mid-half so each is stable around its k or k# rise
        for (int i = 0; i < 4; i++) begin
            slot(i[0] ? 3 : 11, -1);
            wdata_o <= d[36*i +: 36];
            bw_n_o <= bw[4*i +: 4];
        end
        slot(11, -1);
        wdata_o <= ~wdata_o;
        bw_n_o <= ~bw_n_o;
    endtask : wr
endmodule : mem_ctrl_model

// ### sim/tb_quad_ddr_burst4_sram_port.sv
`timescale 1ns/1ns
module tb_quad_ddr_burst4_sram_port;
    localparam logic [143:0] PAT = {36'h1_2345_6789, 36'h9_8765_4321,
                                    36'ha_5a5a_5a5a, 36'h5_a5a5_a5a5};
    logic mclk, rst_n, k, kn, rsel_n, wsel_n, byp_n, oe, valid, echo, echo_inv;
    logic [3:0] addr, bw_n;
    logic [35:0] wdata, rd_data;
    logic [35:0] exp [64];
    logic [35:0] beats [$];
    logic last_echo;
    int t_first, nb, cyc, fail_count, comparisons;
    quad_ddr_burst4_sram_port #(.ADDR_W(4)) i_dut (.mclk_i(mclk), .rst_n_i(rst_n),
        .main_in_edge_i(k), .main_in_edge_inv_i(kn), .read_select_n_i(rsel_n),
        .write_select_n_i(wsel_n), .dll_bypass_n_i(byp_n), .addr_in_i(addr),
        .wr_data_i(wdata), .byte_write_n_i(bw_n), .rd_data_o(rd_data), .rd_data_oe_o(oe),
        .out_valid_flag_o(valid), .echo_out_edge_o(echo), .echo_out_edge_inv_o(echo_inv));
    mem_ctrl_model i_ctrl (.mclk_i(mclk), .rst_n_i(rst_n), .k_o(k), .kn_o(kn),
        .rsel_n_o(rsel_n), .wsel_n_o(wsel_n), .addr_o(addr), .wdata_o(wdata), .bw_n_o(bw_n));
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            $display("[ERR] %0t %s", $time, msg);
            fail_count++;
        end
    endtask : chk
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // hang guard, generous against the fewer than 1500 cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 8000) begin
            $display("[ERR] %0t timeout", $time);
            fail_count++;
            test_done();
        end
    end
    // beats are taken where the echo toggles under valid; only the first four count
    always @(negedge mclk) begin
        last_echo <= echo;
        if (valid !== 1'b1) nb <= 0;
        else if (echo !== last_echo && nb < 4) begin
            if (nb == 0) t_first <= i_ctrl.ncyc;
            beats.push_back(rd_data);
            nb <= nb + 1;
        end
        if (rst_n) chk(oe === valid, "oe differs from valid");
    end
    task automatic wr_do(input logic [3:0] a, input int par, input logic [143:0] d,
                         input logic [15:0] bw);
        i_ctrl.wr(a, par, d, bw);
        for (int i = 0; i < 16; i++) begin
            if (par == 1 && !bw[i]) exp[{a, i[3:2]}][9*i[1:0] +: 9] = d[36*i[3:2]+9*i[1:0] +: 9];
        end
    endtask : wr_do
    task automatic rd_chk(input logic [3:0] a, input int lat);
        int t;
        int w;
        beats.delete();
        i_ctrl.rd(a, 0, t);
        w = 0;
        while (beats.size() < 4 && w < 80) begin
            @(negedge mclk);
            w++;
        end
        chk(beats.size() == 4, "burst short");
        if (beats.size() == 4) begin
            chk(t_first - t > lat * 8 && t_first - t <= lat * 8 + 5, "latency");
            for (int i = 0; i < 4; i++) chk(beats[i] === exp[{a, i[1:0]}], "data");
        end
        repeat (16) @(negedge mclk);
        chk(valid === 1'b0 && beats.size() == 4, "burst end");
    endtask : rd_chk
    task automatic t_basic();
        wr_do(4'h3, 1, PAT, 16'h0000);
        rd_chk(4'h3, 5);
        $display("test basic done");
    endtask : t_basic
    task automatic t_lanes();
        wr_do(4'h3, 1, ~PAT, 16'h7bde);
        rd_chk(4'h3, 5);
        $display("test lanes done");
    endtask : t_lanes
    task automatic t_refuse();
        int t;
        beats.delete();
        i_ctrl.rd(4'h3, 1, t);
        repeat (60) @(negedge mclk);
        chk(beats.size() == 0, "read on write edge taken");
        wr_do(4'h3, 0, 144'h0, 16'h0000);
        rd_chk(4'h3, 5);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_concur();
        wr_do(4'h5, 1, PAT, 16'h0000);
        // the write waits one slot so its beats come in while read beats go out
        fork
            begin
                i_ctrl.slot(7, 0);
                wr_do(4'h5, 1, ~PAT, 16'h0000);
            end
            rd_chk(4'h3, 5);
        join
        rd_chk(4'h5, 5);
        $display("test concurrent done");
    endtask : t_concur
    task automatic t_echo();
        int n;
        int m;
        logic e;
        logic f;
        n = 0;
        m = 0;
        e = echo;
        f = echo_inv;
        repeat (64) begin
            @(negedge mclk);
            if (echo !== e) n++;
            if (echo_inv !== f) m++;
            e = echo;
            f = echo_inv;
        end
        chk(n >= 7 && n <= 9, "echo idle");
        chk(m >= 7 && m <= 9, "echo inv idle");
        $display("test echo done");
    endtask : t_echo
    task automatic t_bypass();
        byp_n = 1'b0;
        repeat (4) @(negedge mclk);
        rd_chk(4'h5, 2);
        // the bypass burst must leave the pipe before the latency changes back
        repeat (16) @(negedge mclk);
        byp_n = 1'b1;
        $display("test bypass done");
    endtask : t_bypass
    initial begin
        rst_n = 1'b0;
        byp_n = 1'b1;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        repeat (40) @(negedge mclk);
        t_basic();
        t_lanes();
        t_refuse();
        t_concur();
        t_echo();
        t_bypass();
        test_done();
    end
endmodule : tb_quad_ddr_burst4_sram_port

// ### src/quad_ddr_burst4_sram_port.sv
`timescale 1ns/1ns
module quad_ddr_burst4_sram_port
    import sram_port_pkg::*;
#(
    parameter int DATA_W = DATA_W_X36,
    parameter int ADDR_W = BURST_ADDR_W_X36,
    parameter int BUF_DEPTH = WBUF_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic main_in_edge_i,
    input wire logic main_in_edge_inv_i,
    input wire logic read_select_n_i,
    input wire logic write_select_n_i,
    input wire logic dll_bypass_n_i,
    input wire logic [ADDR_W-1:0] addr_in_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic [DATA_W/BYTE_W-1:0] byte_write_n_i,
    output logic [DATA_W-1:0] rd_data_o,
    output logic rd_data_oe_o,
    output logic out_valid_flag_o,
    output logic echo_out_edge_o,
    output logic echo_out_edge_inv_o
);
    localparam int LANES = DATA_W / BYTE_W;
    localparam int PW = 5 + ADDR_W + DATA_W + LANES;
    localparam int MW = ADDR_W + BEAT_W;
    localparam int SLOTS = RD_LAT_HALF + BURST_LEN - 1;
    localparam int PTR_W = (BUF_DEPTH > 2) ? $clog2(BUF_DEPTH) : 1;
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);

    // only the two organisations are served
    if (!(DATA_W == DATA_W_X36 || DATA_W == DATA_W_X18)) begin : bad_width
        $error("data width must be 36 or 18");
    end
    if (ADDR_W < 1 || ADDR_W > BURST_ADDR_W_X18) begin : bad_addr
        $error("address width out of range");
    end
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : bad_depth
        $error("buffer depth must be a power of two, at least two");
    end

    // every pin passes two flops; all share one delay so they stay aligned
    logic [PW-1:0] pin_s1_ff;
    logic [PW-1:0] pin_s2_ff;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end else begin
            pin_s1_ff <= {main_in_edge_i, main_in_edge_inv_i, read_select_n_i,
                          write_select_n_i, dll_bypass_n_i, addr_in_i, wr_data_i,
                          byte_write_n_i};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    logic k_s;
    logic kn_s;
    logic rsel_n_s;
    logic wsel_n_s;
    logic byp_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] wd_s;
    logic [LANES-1:0] bw_n_s;
    assign {k_s, kn_s, rsel_n_s, wsel_n_s, byp_n_s, addr_s, wd_s, bw_n_s} = pin_s2_ff;

    // edge history and command phase
    logic k_d_ff, nxt_k_d;
    logic kn_d_ff, nxt_kn_d;
    logic phase_ff, nxt_phase;
    logic k_rise;
    logic kn_rise;
    logic half;
    logic rd_cmd;
    logic wr_cmd;
    always_comb begin
        nxt_k_d = k_s;
        nxt_kn_d = kn_s;
        k_rise = k_s & ~k_d_ff;
        kn_rise = kn_s & ~kn_d_ff;
        half = k_rise | kn_rise;
        // reads on even edges, writes on odd ones: no shared-edge conflict
        nxt_phase = k_rise ? ~phase_ff : phase_ff;
        rd_cmd = k_rise & ~phase_ff & ~rsel_n_s;
        wr_cmd = k_rise & phase_ff & ~wsel_n_s;
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            k_d_ff <= 1'b0;
            kn_d_ff <= 1'b0;
            phase_ff <= 1'b0;
        end else begin
            k_d_ff <= nxt_k_d;
            kn_d_ff <= nxt_kn_d;
            phase_ff <= nxt_phase;
        end
    end

    // write beat capture; the command address is kept apart from the
    // running base so a new write may be taken during the old one
    logic wr_arm_ff, nxt_wr_arm;
    logic wr_busy_ff, nxt_wr_busy;
    logic [BEAT_W-1:0] wr_beat_ff, nxt_wr_beat;
    logic [ADDR_W-1:0] wr_cmd_a_ff, nxt_wr_cmd_a;
    logic [ADDR_W-1:0] wr_base_ff, nxt_wr_base;
    logic cap_vld_ff, nxt_cap_vld;
    logic [MW-1:0] cap_addr_ff, nxt_cap_addr;
    logic [DATA_W-1:0] cap_data_ff, nxt_cap_data;
    logic [LANES-1:0] cap_mask_ff, nxt_cap_mask;
    logic buf_rdy;
    logic push;
    always_comb begin
        nxt_wr_arm = wr_arm_ff;
        nxt_wr_busy = wr_busy_ff;
        nxt_wr_beat = wr_beat_ff;
        nxt_wr_cmd_a = wr_cmd_a_ff;
        nxt_wr_base = wr_base_ff;
        nxt_cap_addr = cap_addr_ff;
        nxt_cap_data = cap_data_ff;
        nxt_cap_mask = cap_mask_ff;
        push = cap_vld_ff & buf_rdy;
        nxt_cap_vld = cap_vld_ff & ~buf_rdy;
        if (k_rise) begin
            nxt_wr_arm = wr_cmd;
        end
        if (wr_cmd) begin
            nxt_wr_cmd_a = addr_s;
        end
        if (k_rise && wr_busy_ff && wr_beat_ff == 2'h2) begin
            nxt_cap_vld = 1'b1;
            nxt_cap_addr = {wr_base_ff, wr_beat_ff};
            nxt_wr_beat = 2'h3;
        end else if (k_rise && wr_arm_ff) begin
            // first beat one cycle after its command
            nxt_cap_vld = 1'b1;
            nxt_cap_addr = {wr_cmd_a_ff, 2'h0};
            nxt_wr_base = wr_cmd_a_ff;
            nxt_wr_beat = 2'h1;
            nxt_wr_busy = 1'b1;
        end
        if (kn_rise && wr_busy_ff && wr_beat_ff[0]) begin
            nxt_cap_vld = 1'b1;
            nxt_cap_addr = {wr_base_ff, wr_beat_ff};
            nxt_wr_beat = wr_beat_ff + 2'h1;
            // fourth beat ends the burst, two and a half cycles after the command
            if (wr_beat_ff == 2'h3) begin
                nxt_wr_busy = 1'b0;
            end
        end
        if (half) begin
            nxt_cap_data = wd_s;
            nxt_cap_mask = ~bw_n_s;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_arm_ff <= 1'b0;
            wr_busy_ff <= 1'b0;
            wr_beat_ff <= '0;
            wr_cmd_a_ff <= '0;
            wr_base_ff <= '0;
            cap_vld_ff <= 1'b0;
            cap_addr_ff <= '0;
            cap_data_ff <= '0;
            cap_mask_ff <= '0;
        end else begin
            wr_arm_ff <= nxt_wr_arm;
            wr_busy_ff <= nxt_wr_busy;
            wr_beat_ff <= nxt_wr_beat;
            wr_cmd_a_ff <= nxt_wr_cmd_a;
            wr_base_ff <= nxt_wr_base;
            cap_vld_ff <= nxt_cap_vld;
            cap_addr_ff <= nxt_cap_addr;
            cap_data_ff <= nxt_cap_data;
            cap_mask_ff <= nxt_cap_mask;
        end
    end

    // write buffer; it drains into the array only when no read needs it
    logic [MW+DATA_W+LANES-1:0] buf_mem_ff [BUF_DEPTH];
    logic [PTR_W-1:0] buf_wp_ff, nxt_buf_wp;
    logic [PTR_W-1:0] buf_rp_ff, nxt_buf_rp;
    logic [CNT_W-1:0] buf_cnt_ff, nxt_buf_cnt;
    logic buf_vld;
    logic pop;
    logic rd_launch;
    logic [MW-1:0] drn_addr;
    logic [DATA_W-1:0] drn_data;
    logic [LANES-1:0] drn_mask;
    always_comb begin
        buf_rdy = buf_cnt_ff < CNT_W'(BUF_DEPTH);
        buf_vld = buf_cnt_ff != '0;
        pop = buf_vld & ~rd_launch;
        nxt_buf_wp = push ? PTR_W'(buf_wp_ff + 1'b1) : buf_wp_ff;
        nxt_buf_rp = pop ? PTR_W'(buf_rp_ff + 1'b1) : buf_rp_ff;
        nxt_buf_cnt = CNT_W'(buf_cnt_ff + push - pop);
        {drn_addr, drn_data, drn_mask} = buf_mem_ff[buf_rp_ff];
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            buf_wp_ff <= '0;
            buf_rp_ff <= '0;
            buf_cnt_ff <= '0;
        end else begin
            buf_wp_ff <= nxt_buf_wp;
            buf_rp_ff <= nxt_buf_rp;
            buf_cnt_ff <= nxt_buf_cnt;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (push) begin
            buf_mem_ff[buf_wp_ff] <= {cap_addr_ff, cap_data_ff, cap_mask_ff};
        end
    end

    // storage array; a masked lane keeps its old byte
    logic [DATA_W-1:0] mem_ff [2**MW];
    always_ff @(posedge mclk_i) begin
        for (int l = 0; l < LANES; l++) begin
            if (pop && drn_mask[l]) begin
                mem_ff[drn_addr][l*BYTE_W +: BYTE_W] <= drn_data[l*BYTE_W +: BYTE_W];
            end
        end
    end

    // read pipeline, shifted on every half-cycle edge
    logic pipe_v_ff [SLOTS];
    logic [ADDR_W-1:0] pipe_a_ff [SLOTS];
    logic nxt_pipe_v [SLOTS];
    logic [ADDR_W-1:0] nxt_pipe_a [SLOTS];
    logic [DATA_W-1:0] nxt_rd_data;
    logic nxt_vld;
    logic nxt_oe;
    logic nxt_echo;
    logic nxt_echo_inv;
    logic [MW-1:0] rd_addr;
    int lat;
    always_comb begin
        lat = byp_n_s ? RD_LAT_HALF : RD_LAT_BYP_HALF;
        rd_launch = 1'b0;
        rd_addr = '0;
        for (int i = 0; i < BURST_LEN; i++) begin
            if (pipe_v_ff[lat - 1 + i]) begin
                rd_launch = half;
                rd_addr = {pipe_a_ff[lat - 1 + i], BEAT_W'(i)};
            end
        end
        for (int j = 0; j < SLOTS; j++) begin
            nxt_pipe_v[j] = pipe_v_ff[j];
            nxt_pipe_a[j] = pipe_a_ff[j];
        end
        if (half) begin
            nxt_pipe_v[0] = rd_cmd;
            nxt_pipe_a[0] = rd_cmd ? addr_s : '0;
            for (int j = 1; j < SLOTS; j++) begin
                nxt_pipe_v[j] = pipe_v_ff[j-1];
                nxt_pipe_a[j] = pipe_a_ff[j-1];
            end
        end
        // outputs move on the same edge as the echo clocks
        nxt_rd_data = rd_launch ? mem_ff[rd_addr] : rd_data_o;
        nxt_vld = half ? rd_launch : out_valid_flag_o;
        nxt_oe = nxt_vld;
        nxt_echo = k_s;
        nxt_echo_inv = kn_s;
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            for (int j = 0; j < SLOTS; j++) begin
                pipe_v_ff[j] <= 1'b0;
                pipe_a_ff[j] <= '0;
            end
            rd_data_o <= '0;
            out_valid_flag_o <= 1'b0;
            rd_data_oe_o <= 1'b0;
            echo_out_edge_o <= 1'b0;
            echo_out_edge_inv_o <= 1'b0;
        end else begin
            pipe_v_ff <= nxt_pipe_v;
            pipe_a_ff <= nxt_pipe_a;
            rd_data_o <= nxt_rd_data;
            out_valid_flag_o <= nxt_vld;
            rd_data_oe_o <= nxt_oe;
            echo_out_edge_o <= nxt_echo;
            echo_out_edge_inv_o <= nxt_echo_inv;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // a select on its own edge is taken, the other kind on that edge is dropped
    rd_phase_a: assert property (k_rise && !phase_ff && !rsel_n_s |=> pipe_v_ff[0])
        else $error("read on a read edge not taken");
    rd_refuse_a: assert property (k_rise && phase_ff |=> !pipe_v_ff[0])
        else $error("read taken on a write edge");
    wr_phase_a: assert property (k_rise && phase_ff && !wsel_n_s |=> wr_arm_ff)
        else $error("write on a write edge not taken");
    wr_refuse_a: assert property (k_rise && !phase_ff |=> !wr_arm_ff)
        else $error("write taken on a read edge");
    wr_first_a: assert property (
        k_rise && wr_arm_ff && !(wr_busy_ff && wr_beat_ff == 2'h2)
        |=> cap_vld_ff && cap_addr_ff[1:0] == 2'h0 && wr_beat_ff == 2'h1)
        else $error("first write beat not taken");
    wr_even_a: assert property (
        kn_rise && wr_busy_ff && wr_beat_ff[0]
        |=> cap_vld_ff && cap_addr_ff[0] && cap_mask_ff == ~$past(bw_n_s))
        else $error("even write beat not taken");
    wr_done_a: assert property (kn_rise && wr_busy_ff && wr_beat_ff == 2'h3 |=> !wr_busy_ff)
        else $error("write burst did not end after fourth beat");
    // slot lat-1 holds the read at the very half edge that launches its first beat
    rd_lat_a: assert property (
        half && byp_n_s && pipe_v_ff[RD_LAT_HALF-1]
        |=> out_valid_flag_o && rd_data_oe_o)
        else $error("read data late in normal mode");
    rd_byp_a: assert property (
        half && !byp_n_s && pipe_v_ff[RD_LAT_BYP_HALF-1]
        |=> out_valid_flag_o)
        else $error("read data late in bypass mode");
    vld_edge_a: assert property ($changed(out_valid_flag_o) |-> $past(half))
        else $error("valid flag moved off an echo edge");
    q_edge_a: assert property ($changed(rd_data_o) |-> $past(rd_launch))
        else $error("read data moved without a launch");
    echo_run_a: assert property ($rose(echo_out_edge_o) |-> $past(k_rise))
        else $error("echo clock not following input clock");

    rd_seen_c: cover property (rd_cmd);
    wr_seen_c: cover property (wr_cmd);
    both_c: cover property (wr_busy_ff && out_valid_flag_o);
    byp_c: cover property (!byp_n_s && rd_launch);
    stall_c: cover property (cap_vld_ff && !buf_rdy);
endmodule : quad_ddr_burst4_sram_port
